// [hdl/ebi_pkg.sv]
/*
  Constants, types and state encoding of the external bus block.
  Assumes a 32-bit APB with 12-bit byte addresses; register byte
  address is four times the low index bits.
*/
package ebi_pkg;

  // register indices; byte address is index times four
  localparam logic [31:0] DATA_WAIT_CTRL_IDX  = 32'hFFFFF060;
  localparam logic [31:0] IDLE_CYCLE_CTRL_IDX = 32'h0FFFF062;
  localparam logic [31:0] SYSTEM_CTRL_IDX     = 32'hFFFFF064;
  localparam logic [31:0] BUS_MODE_IDX        = 32'hFFFFF066;
  localparam logic [31:0] BUS_STATUS_IDX      = 32'hFFFFF068;
  localparam int unsigned IDX_W               = 10;

  // reset values and writable masks
  localparam logic [15:0] DWC_RESET  = 16'hFFFF;
  localparam logic [15:0] BCC_RESET  = 16'hAAAA;
  localparam logic [15:0] BCC_MASK   = 16'hAAAA;
  localparam logic [7:0]  SYC_MASK   = 8'h01;
  localparam int unsigned SSEL_BIT   = 0;
  localparam int unsigned EXP_BIT    = 0;
  localparam int unsigned ADR_BIT    = 1;

  // address map
  localparam logic [3:0]  BLK_ROM     = 4'h0;
  localparam logic [3:0]  BLK_TOP     = 4'hF;
  localparam logic [11:0] PERIPH_PAGE = 12'hFFF;
  localparam logic [23:0] ADDR_HI     = 24'h000002;

  // access clocks per resource
  localparam logic [2:0] CLK_ROM_FETCH = 3'h1;
  localparam logic [2:0] CLK_ROM_OPER  = 3'h3;
  localparam logic [2:0] CLK_RAM_FETCH = 3'h3;
  localparam logic [2:0] CLK_RAM_OPER  = 3'h1;
  localparam logic [2:0] CLK_PERI_OPER = 3'h3;
  localparam logic [3:0] WAIT_CNT_MAX  = 4'hF;

  // access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_T1 = 3'h1, ST_T2 = 3'h3, ST_T3 = 3'h2,
    ST_TI   = 3'h6, ST_TW = 3'h7, ST_INT = 3'h4
  } ebi_state_t;

  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    logic [1:0]  size;
    logic [23:0] addr;
    logic [31:0] wdata;
  } ebi_req_t;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [31:0] rdata;
  } ebi_rsp_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] ad_out;
    logic        ad_oe;
    logic        address_latch_strobe;
    logic        data_strobe_n;
    logic        rw;
    logic        low_byte_enable_n;
    logic        high_byte_enable_n;
    logic        read_strobe_n;
    logic        write_low_strobe_n;
    logic        write_high_strobe_n;
  } ebi_pins_t;

  typedef struct packed {
    logic addr_oe;
    logic latch_oe;
    logic set0_oe;
    logic set1_oe;
    logic high_be_oe;
  } ebi_pin_oe_t;

  localparam ebi_pins_t PINS_IDLE = '{addr: 24'h0, ad_out: 16'h0, ad_oe: 1'b0,
    address_latch_strobe: 1'b0, rw: 1'b1, default: 1'b1};

endpackage : ebi_pkg

// [hdl/ebi_bus_ctrl.sv]
/*
  External bus controller: splits CPU accesses into bus cycles,
  inserts programmed, external and idle states, APB registers.
  Assumes CPU requests on pclk, aligned halfword and word addresses.
*/
`timescale 1ns/1ns
module ebi_bus_ctrl
  import ebi_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire ebi_req_t    req,
  output logic             req_ready,
  output ebi_rsp_t         rsp,
  input  wire logic        periph_wait,
  input  wire logic        wait_n,
  input  wire logic [15:0] ad_in,
  output ebi_pins_t        pins,
  output ebi_pin_oe_t      pin_oe
);

  typedef struct packed {
    ebi_state_t  st;
    logic [15:0] data_wait_control;
    logic [15:0] bcc;
    logic [7:0]  system_control;
    logic [1:0]  mode;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  wait_sync;
    logic [15:0] ad_s1;
    logic [15:0] ad_s2;
    ebi_req_t    cur;
    logic        peri;
    logic        hi_half;
    logic [1:0]  waits_left;
    logic [2:0]  cnt;
    logic [3:0]  wait_cnt;
    logic [3:0]  last_waits;
    logic        req_ready;
    ebi_rsp_t    rsp;
    ebi_pins_t   pins;
    ebi_pin_oe_t oe;
  } ebi_regs_t;

  localparam ebi_regs_t REGS_RESET = '{st: ST_IDLE, data_wait_control: DWC_RESET,
    bcc: BCC_RESET, wait_sync: 2'h3, req_ready: 1'b1, pins: PINS_IDLE,
    default: '0};

  ebi_regs_t       q;
  ebi_regs_t       d;
  logic [31:0]     rd_value;
  logic            hit;
  logic [IDX_W-1:0] apb_idx;
  logic            apb_wr;
  logic            start;
  logic [3:0]      req_blk;
  logic            req_peri;
  logic [1:0]      req_waits;
  logic            idle_en;
  logic            wait_act;
  logic            more;
  logic            lane_lo;
  logic            lane_hi;
  logic [15:0]     wr_half;
  ebi_pins_t       t2_pins;

  ////////////////////////////////////////////////////////////////////
  // decode helpers
  assign apb_idx   = paddr[IDX_W+1:2];
  assign apb_wr    = psel & penable & pwrite & q.pready;
  assign start     = (q.st == ST_IDLE) & req.valid & q.req_ready;
  assign req_blk   = req.addr[23:20];
  assign req_peri  = (req.addr[23:12] == PERIPH_PAGE);
  // pair n field at bits 2n+1:2n, block 0 forced to zero
  assign req_waits = (req_blk == BLK_ROM) ? 2'h0
                   : q.data_wait_control[{req.addr[23:21], 1'b0} +: 2];
  assign idle_en   = q.bcc[{q.cur.addr[23:21], 1'b1}];
  assign wait_act  = ~q.wait_sync[1];
  assign more      = (q.cur.size == SIZE_WORD) & ~q.hi_half;

  // byte lanes; odd byte uses the high lane
  assign lane_lo = (q.cur.size != SIZE_BYTE) | ~q.cur.addr[0];
  assign lane_hi = (q.cur.size != SIZE_BYTE) | q.cur.addr[0];
  // byte copied to both lanes, the unused one is invalid
  assign wr_half = (q.cur.size == SIZE_BYTE) ? {2{q.cur.wdata[7:0]}}
                 : q.hi_half ? q.cur.wdata[31:16] : q.cur.wdata[15:0];

  // strobe state held from T2 through wait states to T3
  assign t2_pins = '{addr: q.pins.addr, ad_out: wr_half,
    ad_oe: q.cur.write, address_latch_strobe: 1'b0, data_strobe_n: 1'b0,
    rw: ~q.cur.write, low_byte_enable_n: ~lane_lo,
    high_byte_enable_n: ~lane_hi, read_strobe_n: q.cur.write,
    write_low_strobe_n: ~(q.cur.write & lane_lo),
    write_high_strobe_n: ~(q.cur.write & lane_hi)};

  // address phase pins
  function automatic ebi_pins_t t1_pins(input logic [23:0] a);
    ebi_pins_t p;
    p = PINS_IDLE;
    p.addr = a;
    p.ad_out = a[15:0];
    p.ad_oe = 1'b1;
    p.address_latch_strobe = 1'b1;
    return p;
  endfunction : t1_pins

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////
  // next state of everything
  always_comb begin
    d = q;
    rd_value = 32'h0;
    hit = 1'b1;
    d.wait_sync = {q.wait_sync[0], wait_n};
    d.ad_s1 = ad_in;
    d.ad_s2 = q.ad_s1;
    d.rsp.done = 1'b0;

    // register read mux
    case (apb_idx)
      DATA_WAIT_CTRL_IDX[IDX_W-1:0]:  rd_value = {16'h0, q.data_wait_control};
      IDLE_CYCLE_CTRL_IDX[IDX_W-1:0]: rd_value = {16'h0, q.bcc};
      SYSTEM_CTRL_IDX[IDX_W-1:0]:     rd_value = {24'h0, q.system_control};
      BUS_MODE_IDX[IDX_W-1:0]:        rd_value = {30'h0, q.mode};
      BUS_STATUS_IDX[IDX_W-1:0]:
        rd_value = {23'h0, q.st != ST_IDLE, 4'h0, q.last_waits};
      default: hit = 1'b0;
    endcase

    // apb slave, zero wait answer
    d.pready = psel & ~penable;
    d.pslverr = 1'b0;
    if (psel && !penable) begin
      d.prdata = rd_value;
      d.pslverr = ~hit;
    end
    if (apb_wr) begin
      case (apb_idx)
        DATA_WAIT_CTRL_IDX[IDX_W-1:0]:
          d.data_wait_control = merge16(q.data_wait_control, pwdata, pstrb);
        IDLE_CYCLE_CTRL_IDX[IDX_W-1:0]:
          d.bcc = merge16(q.bcc, pwdata, pstrb) & BCC_MASK;
        SYSTEM_CTRL_IDX[IDX_W-1:0]:
          if (pstrb[0]) d.system_control = pwdata[7:0] & SYC_MASK;
        BUS_MODE_IDX[IDX_W-1:0]:
          if (pstrb[0]) d.mode = pwdata[1:0];
        default: ;
      endcase
    end

    // pin functions follow mode and strobe set
    d.oe.latch_oe   = q.mode[EXP_BIT];
    d.oe.addr_oe    = q.mode[EXP_BIT] & q.mode[ADR_BIT];
    d.oe.set0_oe    = q.mode[EXP_BIT] & ~q.system_control[SSEL_BIT];
    d.oe.set1_oe    = q.mode[EXP_BIT] & q.system_control[SSEL_BIT];
    d.oe.high_be_oe = q.mode[EXP_BIT];

    // access sequencer
    case (q.st)
      ST_IDLE: begin
        if (start) begin
          d.cur = req;
          d.peri = 1'b0;
          d.hi_half = 1'b0;
          d.rsp.err = 1'b0;
          d.rsp.rdata = 32'h0;
          d.req_ready = 1'b0;
          d.st = ST_INT;
          if (req_blk == BLK_ROM) begin
            d.cnt = (req.fetch ? CLK_ROM_FETCH : CLK_ROM_OPER) - 3'h1;
          end else if (req_blk == BLK_TOP && req_peri) begin
            d.peri = 1'b1;
            d.cnt = CLK_PERI_OPER - 3'h1;
            if (req.fetch) begin
              d.st = ST_IDLE;
              d.req_ready = 1'b1;
              d.rsp.done = 1'b1;
              d.rsp.err = 1'b1;
            end
          end else if (req_blk == BLK_TOP) begin
            d.cnt = (req.fetch ? CLK_RAM_FETCH : CLK_RAM_OPER) - 3'h1;
          end else if (q.mode[EXP_BIT]) begin
            d.st = ST_T1;
            d.pins = t1_pins(req.addr);
            d.waits_left = req_waits;
            d.wait_cnt = 4'h0;
          end else begin
            d.st = ST_IDLE;
            d.req_ready = 1'b1;
            d.rsp.done = 1'b1;
            d.rsp.err = 1'b1;
          end
        end
      end
      // internal access; only peripherals add their own waits
      ST_INT: begin
        if (q.cnt != 3'h0) begin
          d.cnt = q.cnt - 3'h1;
        end else if (!(q.peri && periph_wait)) begin
          d.st = ST_IDLE;
          d.req_ready = 1'b1;
          d.rsp.done = 1'b1;
        end
      end
      ST_T1: begin
        d.st = ST_T2;
        d.pins = t2_pins;
      end
      // programmed or external wait, whichever lasts longer
      ST_T2, ST_TW: begin
        if (q.waits_left != 2'h0 || wait_act) begin
          d.st = ST_TW;
          if (q.waits_left != 2'h0) d.waits_left = q.waits_left - 2'h1;
          if (q.wait_cnt != WAIT_CNT_MAX) d.wait_cnt = q.wait_cnt + 4'h1;
        end else begin
          d.st = ST_T3;
        end
      end
      // end of data phase, capture read data
      ST_T3: begin
        d.pins = PINS_IDLE;
        d.last_waits = q.wait_cnt;
        if (q.cur.size == SIZE_BYTE) begin
          d.rsp.rdata = {24'h0, q.cur.addr[0] ? q.ad_s2[15:8] : q.ad_s2[7:0]};
        end else if (q.hi_half) begin
          d.rsp.rdata[31:16] = q.ad_s2;
        end else begin
          d.rsp.rdata[15:0] = q.ad_s2;
        end
        if (idle_en) begin
          d.st = ST_TI;
        end else if (more) begin
          d.st = ST_T1;
          d.hi_half = 1'b1;
          d.pins = t1_pins(q.cur.addr | ADDR_HI);
          d.waits_left = q.data_wait_control[{q.cur.addr[23:21], 1'b0} +: 2];
          d.wait_cnt = 4'h0;
        end else begin
          d.st = ST_IDLE;
          d.req_ready = 1'b1;
          d.rsp.done = 1'b1;
        end
      end
      ST_TI: begin
        if (more) begin
          d.st = ST_T1;
          d.hi_half = 1'b1;
          d.pins = t1_pins(q.cur.addr | ADDR_HI);
          d.waits_left = q.data_wait_control[{q.cur.addr[23:21], 1'b0} +: 2];
          d.wait_cnt = 4'h0;
        end else begin
          d.st = ST_IDLE;
          d.req_ready = 1'b1;
          d.rsp.done = 1'b1;
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= REGS_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign req_ready = q.req_ready;
  assign rsp       = q.rsp;
  assign pins      = q.pins;
  assign pin_oe    = q.oe;

  ////////////////////////////////////////////////////////////////////
  // checks
  rom_fetch_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    start && req_blk == BLK_ROM && req.fetch |=> q.st == ST_INT ##1 q.rsp.done)
    else $error("rom fetch not one clock");

  rom_oper_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    start && req_blk == BLK_ROM && !req.fetch |=> ##3 q.rsp.done)
    else $error("rom operand not three clocks");

  ram_nowait_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    start && req_blk == BLK_TOP && !req_peri && !req.fetch |=> ##1 q.rsp.done)
    else $error("ram operand not one clock");

  prog_wait_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_T2 && q.waits_left == 2'h3 |=> (q.st == ST_TW) [*3])
    else $error("three programmed waits missing");

  ext_wait_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    (q.st == ST_T2 || q.st == ST_TW) && wait_act |=> q.st == ST_TW)
    else $error("external wait ignored");

  int_nowait_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_INT && q.cnt == 3'h0 && !q.peri |=> q.rsp.done)
    else $error("internal access stretched");

  idle_state_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_T3 && idle_en |=> q.st == ST_TI ##1 q.st != ST_T2)
    else $error("idle state not inserted");

  word_order_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_T3 && more && !idle_en |=> q.st == ST_T1 && q.pins.addr[1])
    else $error("higher halfword not second");

  strobe_sets_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.mode[EXP_BIT] && $stable(q.mode) && $stable(q.system_control)
      |=> q.oe.set1_oe == $past(q.system_control[SSEL_BIT]) && q.oe.set0_oe != q.oe.set1_oe)
    else $error("strobe set enables wrong");

endmodule : ebi_bus_ctrl

// [tb/ebi_ext_mem.sv]
/*
  External memory model on the far side of the bus pins: sixteen
  halfwords, optional wait requests. Assumes registered pins, one clock.
*/
`timescale 1ns/1ns
module ebi_ext_mem
  import ebi_pkg::*;
(
  input  wire logic        pclk,
  input  wire ebi_pins_t   pins,
  input  wire ebi_pin_oe_t pin_oe,
  input  wire logic [3:0]  stall,
  input  wire logic        hold_wait,
  output logic      [15:0] ad_in,
  output logic             wait_n
);
  logic [15:0] mem [16];
  logic [3:0]  idx_q = 4'h0;
  logic [3:0]  last_idx_q = 4'h0;
  logic [3:0]  cnt_q = 4'h0;
  logic [15:0] last_q = 16'h0;
  logic        rd;
  logic        wr_lo;
  logic        wr_hi;

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  end

  // strobe decode for both strobe sets
  assign rd    = (pin_oe.set0_oe & ~pins.data_strobe_n & pins.rw) | (pin_oe.set1_oe & ~pins.read_strobe_n);
  assign wr_lo = pin_oe.set0_oe ? ~pins.data_strobe_n & ~pins.rw & ~pins.low_byte_enable_n
                                : ~pins.write_low_strobe_n;
  assign wr_hi = pin_oe.set0_oe ? ~pins.data_strobe_n & ~pins.rw & ~pins.high_byte_enable_n
                                : pin_oe.set1_oe & ~pins.write_high_strobe_n;
  // released bus shows a changing value, never the last data
  assign ad_in  = rd ? mem[idx_q] : ~last_q;
  // wait request for the first stall cycles of each strobe
  assign wait_n = ~(hold_wait | ((rd | wr_lo | wr_hi) & (cnt_q < stall)));

  ////////////////////////////////////////////////////////////////
  // address latch, write capture, strobe cycle count
  always @(posedge pclk) begin
    last_q <= ad_in;
    cnt_q  <= (rd | wr_lo | wr_hi) ? cnt_q + 4'h1 : 4'h0;
    if (pins.address_latch_strobe & pin_oe.latch_oe) idx_q <= pins.ad_out[4:1];
    if (wr_lo) mem[idx_q][7:0] <= pins.ad_out[7:0];
    if (wr_hi) mem[idx_q][15:8] <= pins.ad_out[15:8];
    if (wr_lo | wr_hi) last_idx_q <= idx_q;
  end
endmodule : ebi_ext_mem

// [tb/external_bus_wait_idle_control_bench.sv]
/*
  Self-checking bench of the external bus block: register access over APB,
  access timing per resource, waits, idle states, strobe sets.
  Assumes the block answers APB with zero waits and the memory model.
*/
`timescale 1ns/1ns
module external_bus_wait_idle_control_bench
  import ebi_pkg::*;
;
  typedef struct packed {
    logic [15:0] data_wait_control;
    logic [15:0] bcc;
    logic        fetch;
    logic [23:0] addr;
    logic [3:0]  lat;
  } ebi_row_t;

  logic        pclk;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  ebi_req_t    req = '0;
  logic        req_ready;
  ebi_rsp_t    rsp;
  logic        periph_wait = 1'b0;
  logic        wait_n;
  logic [15:0] ad_in;
  ebi_pins_t   pins;
  ebi_pin_oe_t pin_oe;
  logic [3:0]  stall = 4'h0;
  logic        hold_wait = 1'b0;
  logic [31:0] rd;
  logic        er;
  int          lat;
  int          error_cnt = 0;
  int          total_checks = 0;
  ebi_row_t    rows [14] = '{
    '{16'h0000, 16'h0000, 1'b0, 24'h100000, 4'h4}, '{16'h0008, 16'h0000, 1'b0, 24'h200000, 4'h6},
    '{16'h000C, 16'h0000, 1'b0, 24'h300000, 4'h7}, '{16'h0004, 16'h0000, 1'b0, 24'h200000, 4'h5},
    '{16'hC000, 16'h0000, 1'b0, 24'hE00000, 4'h7}, '{16'h3FFF, 16'h0000, 1'b0, 24'hE00000, 4'h4},
    '{16'h0000, 16'h0008, 1'b0, 24'h200000, 4'h5}, '{16'h0000, 16'h0002, 1'b0, 24'h200000, 4'h4},
    '{16'hFFFF, 16'hAAAA, 1'b1, 24'h000000, 4'h2}, '{16'hFFFF, 16'hAAAA, 1'b0, 24'h000000, 4'h4},
    '{16'hFFFF, 16'hAAAA, 1'b1, 24'hF00000, 4'h4}, '{16'hFFFF, 16'hAAAA, 1'b0, 24'hF00000, 4'h2},
    '{16'hFFFF, 16'hAAAA, 1'b0, 24'hFFF000, 4'h4}, '{16'hFFFF, 16'hAAAA, 1'b0, 24'h100000, 4'h8}};

  ebi_bus_ctrl ebi_bus_ctrl_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .req, .req_ready, .rsp, .periph_wait, .wait_n,
    .ad_in, .pins, .pin_oe);
  ebi_ext_mem ebi_ext_mem_i (.pclk, .pins, .pin_oe, .stall, .hold_wait, .ad_in, .wait_n);

  // clock source
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one APB transfer, entered just after a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never lands on this release
    @(posedge pclk);
  endtask : apb

  // one CPU request; lat is edges from take to done
  task cpu(input logic f, input logic w, input logic [1:0] sz, input logic [23:0] a,
           input logic [31:0] d);
    int n;
    n = 0;
    req <= '{valid: 1'b1, fetch: f, write: w, size: sz, addr: a, wdata: d};
    @(posedge pclk);
    req.valid <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.done !== 1'b1);
    lat = n;
  endtask : cpu

  task conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////
  // main sequence: table of access timings, then awkward cases
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 12'h198, 32'h3);
    for (int i = 0; i < 14; i++) begin
      apb(1'b1, 12'h180, {16'h0, rows[i].data_wait_control});
      apb(1'b1, 12'h188, {16'h0, rows[i].bcc});
      cpu(rows[i].fetch, 1'b0, SIZE_HALF, rows[i].addr, 32'h0);
      check("latency", lat, {28'h0, rows[i].lat});
    end
    // word split into two halves, low half first
    cpu(1'b0, 1'b1, SIZE_WORD, 24'h100000, 32'h12345678);
    check("low half", ebi_ext_mem_i.mem[0], 32'h5678);
    check("high half", ebi_ext_mem_i.mem[1], 32'h1234);
    check("second half", ebi_ext_mem_i.last_idx_q, 32'h1);
    // read back without idle state, second half follows T3 at once
    apb(1'b1, 12'h188, 32'h0);
    cpu(1'b0, 1'b0, SIZE_WORD, 24'h100000, 32'h0);
    check("word read", rsp.rdata, 32'h12345678);
    // second strobe set, odd byte on high lane
    apb(1'b1, 12'h190, 32'h1);
    repeat (2) @(posedge pclk);
    check("set1 oe", {pin_oe.set0_oe, pin_oe.set1_oe, pin_oe.high_be_oe}, 32'h3);
    cpu(1'b0, 1'b1, SIZE_BYTE, 24'h100005, 32'h000000A5);
    check("odd byte", ebi_ext_mem_i.mem[2], 32'hA500);
    cpu(1'b0, 1'b0, SIZE_BYTE, 24'h100005, 32'h0);
    check("byte read", rsp.rdata[7:0], 32'hA5);
    apb(1'b1, 12'h190, 32'h0);
    repeat (2) @(posedge pclk);
    check("set0 oe", {pin_oe.set0_oe, pin_oe.set1_oe, pin_oe.high_be_oe}, 32'h5);
    // external wait outlasting two programmed waits; they cover the sync delay
    apb(1'b1, 12'h180, 32'h2);
    apb(1'b1, 12'h188, 32'h0);
    stall <= 4'h6;
    cpu(1'b0, 1'b0, SIZE_HALF, 24'h100000, 32'h0);
    apb(1'b0, 12'h1A0, 32'h0);
    check("wait seen", {28'h0, rd[3:0]}, 32'h8);
    check("wait timing", lat, 32'hC);
    // short external wait hidden by three programmed waits
    apb(1'b1, 12'h180, 32'hFFFF);
    stall <= 4'h1;
    cpu(1'b0, 1'b0, SIZE_HALF, 24'h100000, 32'h0);
    apb(1'b0, 12'h1A0, 32'h0);
    check("waits or", rd[3:0], 32'h3);
    // wait pin held low has no effect inside
    stall     <= 4'h0;
    hold_wait <= 1'b1;
    cpu(1'b0, 1'b0, SIZE_HALF, 24'hFFF000, 32'h0);
    check("periph", lat, 32'h4);
    cpu(1'b0, 1'b0, SIZE_HALF, 24'hF00000, 32'h0);
    check("ram", lat, 32'h2);
    cpu(1'b1, 1'b0, SIZE_HALF, 24'hFFF000, 32'h0);
    check("peri fetch lat", lat, 32'h1);
    check("peri fetch err", rsp.err, 32'h1);
    hold_wait <= 1'b0;
    // bus modes off: external refused, pins released
    apb(1'b1, 12'h198, 32'h0);
    cpu(1'b0, 1'b0, SIZE_HALF, 24'h100000, 32'h0);
    check("err lat", lat, 32'h1);
    check("err", rsp.err, 32'h1);
    check("pin oe", pin_oe, 32'h0);
    // second reset mid-run, register defaults and masks
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h180, 32'h0);
    check("dwc reset", rd, 32'hFFFF);
    apb(1'b0, 12'h188, 32'h0);
    check("bcc reset", rd, 32'hAAAA);
    apb(1'b1, 12'h188, 32'hFFFF);
    apb(1'b0, 12'h188, 32'h0);
    check("bcc even", rd, 32'hAAAA);
    apb(1'b1, 12'h180, 32'h1234);
    apb(1'b0, 12'h180, 32'h0);
    check("dwc rw", rd, 32'h1234);
    apb(1'b0, 12'h1FC, 32'h0);
    check("unmapped", er, 32'h1);
    conclude();
  end

  // watchdog against a hung handshake
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
endmodule : external_bus_wait_idle_control_bench
